// file: rtl/adc_cfg_pkg.sv
package adc_cfg_pkg;

    // Configuration word field positions.
    localparam int SS_BIT      = 15;
    localparam int MUX_LSB     = 12;
    localparam int GAIN_LSB    = 9;
    localparam int MODE_BIT    = 8;
    localparam int RATE_LSB    = 5;
    localparam int TEMP_BIT    = 4;
    localparam int PULL_BIT    = 3;
    localparam int WVC_LSB     = 1;
    localparam int RSVD_BIT    = 0;

    // Reset values and codes.
    localparam logic [15:0] CFG_RESET   = 16'h058b;
    localparam logic [1:0]  WVC_VALID   = 2'h1;
    localparam logic [15:0] DATA_RESET  = 16'h0000;

    // Frame shape.
    localparam int WORD_BITS  = 16;
    localparam int FRAME_BITS = 32;

    // Serial clock inactivity timeout.
    localparam int  CLK_MHZ        = 200;
    localparam int  TIMEOUT_MS     = 28;
    localparam int  TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ / 1000 * 1000;

    // Buffer of completed conversions.
    localparam int FIFO_DEPTH = 8;

    // Full-scale range in millivolts; gain codes 5 to 7 all map to FSR_0256.
    typedef enum logic [2:0] {
        FSR_6144, FSR_4096, FSR_2048, FSR_1024, FSR_0512, FSR_0256
    } fsr_t;

    typedef struct packed {
        fsr_t       fullScaleRange;
        logic       continuous;
        logic [9:0] samplesPerSec;
        logic       tempSensor;
        logic       pullupEnable;
        logic [2:0] inputMux;
    } adc_ctrl_t;

    typedef enum logic [1:0] { LINK_IDLE, LINK_SHIFT, LINK_DONE } link_state_t;

endpackage : adc_cfg_pkg

// file: rtl/conv_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module conv_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    // Filling side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wrPtr_r;
    logic [AW:0]      rdPtr_r;
    logic [AW:0]      count;

    assign count    = wrPtr_r - rdPtr_r;
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr_r[AW-1:0]];

    always_ff @(posedge core_clk) begin
        if (inValid && inReady) begin
            mem[wrPtr_r[AW-1:0]] <= inData;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_r <= '0;
        end else if (inValid && inReady) begin
            wrPtr_r <= wrPtr_r + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdPtr_r <= '0;
        end else if (outValid && outReady) begin
            rdPtr_r <= rdPtr_r + 1'b1;
        end
    end
endmodule // conv_fifo
`default_nettype wire

// file: rtl/adc_config_serial_port.sv
`timescale 1ns/10ps
`default_nettype none
module adc_config_serial_port
    import adc_cfg_pkg::*;
(
    // Core clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Serial link, clocked by the master
    input  wire logic        sclk,
    input  wire logic        csN,
    input  wire logic        dataIn,
    output logic             dataOutReady,
    output logic             dataOutReadyOe,
    // Converter side: results and conversion status
    input  wire logic        convValid,
    output logic             convReady,
    input  wire logic [15:0] convData,
    input  wire logic        convBusy,
    // Decoded configuration and conversion start
    output adc_ctrl_t        ctrl,
    output logic             singleShotStart
);
    // Core-domain state, plus the sclk-clocked toutSync_r.
    logic [15:0] cfgWord_r;
    logic [15:0] outWord_r;
    logic        newData_r;
    logic        fifoValid;
    logic [15:0] fifoData;
    logic [27:0] lowCount_r;
    logic        timeout_r;
    logic [2:0]  csSync_r;
    logic [1:0]  sclkSync_r;
    logic [2:0]  doneSync_r;
    logic [1:0]  toutSync_r;

    // Link-domain state, plus the core_clk-clocked readyLvl_r.
    link_state_t linkState_r;
    logic [5:0]  bitCount_r;
    logic [15:0] rxShift_r;
    logic [15:0] txShift_r;
    logic [15:0] rxWord_r;
    logic        doneTgl_r;
    logic [1:0]  outSync_r;
    logic        sdo_r;
    logic        readyLvl_r;

    conv_fifo #(
        .WIDTH (16),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .inValid  (convValid),
        .inReady  (convReady),
        .inData   (convData),
        .outValid (fifoValid),
        .outReady (csSync_r[1]),
        .outData  (fifoData)
    );

    // Results only move into the output word while deselected, so a frame
    // in flight never sees its data change underneath it.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            outWord_r <= DATA_RESET;
        end else if (fifoValid && csSync_r[1]) begin
            outWord_r <= fifoData;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            newData_r <= 1'b0;
        end else if (fifoValid && csSync_r[1]) begin
            newData_r <= 1'b1;
        end else if (csSync_r[2] && !csSync_r[1]) begin
            newData_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            csSync_r   <= 3'h7;
            sclkSync_r <= 2'h0;
            doneSync_r <= 3'h0;
        end else begin
            csSync_r   <= {csSync_r[1:0], csN};
            sclkSync_r <= {sclkSync_r[0], sclk};
            doneSync_r <= {doneSync_r[1:0], doneTgl_r};
        end
    end

    // Timeout counter runs on the core clock since sclk stops while low.
    // The flag holds until deselect, so the link side still sees it on
    // the next falling edges after the clock has started again.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCount_r <= '0;
            timeout_r  <= 1'b0;
        end else if (csSync_r[1]) begin
            lowCount_r <= '0;
            timeout_r  <= 1'b0;
        end else if (sclkSync_r[1]) begin
            lowCount_r <= '0;
        end else if (lowCount_r >= 28'(TIMEOUT_CYCLES)) begin
            timeout_r  <= 1'b1;
        end else begin
            lowCount_r <= lowCount_r + 28'h1;
        end
    end

    // A full word lands here once per frame; invalid codes are dropped.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfgWord_r <= CFG_RESET;
        end else if (doneSync_r[2] != doneSync_r[1]
                     && rxWord_r[WVC_LSB +: 2] == WVC_VALID) begin
            cfgWord_r <= {1'b0, rxWord_r[14:1], 1'b1};
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            singleShotStart <= 1'b0;
        end else begin
            singleShotStart <= doneSync_r[2] != doneSync_r[1]
                && rxWord_r[WVC_LSB +: 2] == WVC_VALID
                && rxWord_r[SS_BIT] && rxWord_r[MODE_BIT]
                && !convBusy;
        end
    end

    always_comb begin
        ctrl.inputMux     = cfgWord_r[MUX_LSB +: 3];
        ctrl.continuous   = !cfgWord_r[MODE_BIT];
        ctrl.tempSensor   = cfgWord_r[TEMP_BIT];
        ctrl.pullupEnable = cfgWord_r[PULL_BIT];
        unique case (cfgWord_r[GAIN_LSB +: 3])
            3'h0:    ctrl.fullScaleRange = FSR_6144;
            3'h1:    ctrl.fullScaleRange = FSR_4096;
            3'h2:    ctrl.fullScaleRange = FSR_2048;
            3'h3:    ctrl.fullScaleRange = FSR_1024;
            3'h4:    ctrl.fullScaleRange = FSR_0512;
            default: ctrl.fullScaleRange = FSR_0256;
        endcase
        unique case (cfgWord_r[RATE_LSB +: 3])
            3'h0:    ctrl.samplesPerSec = 10'd8;
            3'h1:    ctrl.samplesPerSec = 10'd16;
            3'h2:    ctrl.samplesPerSec = 10'd32;
            3'h3:    ctrl.samplesPerSec = 10'd64;
            3'h4:    ctrl.samplesPerSec = 10'd128;
            3'h5:    ctrl.samplesPerSec = 10'd250;
            3'h6:    ctrl.samplesPerSec = 10'd475;
            default: ctrl.samplesPerSec = 10'd860;
        endcase
    end

    // Timeout crosses into the link domain as a level.
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            toutSync_r <= 2'h0;
        end else begin
            toutSync_r <= {toutSync_r[0], timeout_r};
        end
    end

    // Receive on falling edges; chip select high resets everything.
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            linkState_r <= LINK_IDLE;
            bitCount_r  <= '0;
            rxShift_r   <= '0;
        end else if (toutSync_r[1]) begin
            linkState_r <= LINK_IDLE;
            bitCount_r  <= '0;
            rxShift_r   <= '0;
        end else begin
            rxShift_r  <= {rxShift_r[14:0], dataIn};
            bitCount_r <= bitCount_r + 6'h1;
            unique case (linkState_r)
                LINK_IDLE:  linkState_r <= LINK_SHIFT;
                LINK_SHIFT: if (bitCount_r == 6'(WORD_BITS - 1)) begin
                    linkState_r <= LINK_DONE;
                end
                LINK_DONE:  linkState_r <= LINK_DONE;
            endcase
        end
    end

    // Captured word and completion toggle; the word is stable well before
    // the toggle is seen in the core domain.
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rxWord_r  <= CFG_RESET;
            doneTgl_r <= 1'b0;
        end else if (!csN && !toutSync_r[1]
                     && bitCount_r == 6'(WORD_BITS - 1)) begin
            rxWord_r  <= {rxShift_r[14:0], dataIn};
            doneTgl_r <= !doneTgl_r;
        end
    end

    // Set by the first rising edge; from then on the pin shows sdo_r while selected.
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            outSync_r <= 2'h0;
        end else begin
            outSync_r <= {outSync_r[0], 1'b1};
        end
    end

    // Transmit on rising edges: result first, then the echoed word.
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            txShift_r <= '0;
            sdo_r     <= 1'b0;
        end else if (bitCount_r == '0) begin
            sdo_r     <= outWord_r[15];
            txShift_r <= {outWord_r[14:0], 1'b0};
        end else if (bitCount_r == 6'(WORD_BITS)) begin
            sdo_r     <= 1'b0;
            txShift_r <= {rxWord_r[14:1], 1'b1, 1'b0};
        end else if (bitCount_r < 6'(FRAME_BITS)) begin
            sdo_r     <= txShift_r[15];
            txShift_r <= {txShift_r[14:0], 1'b0};
        end
    end

    // Before the first edge the pin shows new-data low.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            readyLvl_r <= 1'b1;
        end else begin
            readyLvl_r <= !newData_r;
        end
    end

    always_comb begin
        if (!csN) begin
            dataOutReady   = outSync_r[0] ? sdo_r : readyLvl_r;
            dataOutReadyOe = 1'b1;
        end else begin
            dataOutReady   = 1'b1;
            dataOutReadyOe = cfgWord_r[PULL_BIT];
        end
    end
endmodule // adc_config_serial_port
`default_nettype wire

// file: tb/adc_cfg_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adc_cfg_monitor
    import adc_cfg_pkg::*;
(
    // Core clock and reset
    input wire logic      core_clk,
    input wire logic      rst_n,
    // Watched ports
    input wire logic      sclk,
    input wire logic      csN,
    input wire logic      convBusy,
    input wire logic      dataOutReady,
    input wire logic      dataOutReadyOe,
    input wire adc_ctrl_t ctrl,
    input wire logic      singleShotStart
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Select is asynchronous, so its synchroniser gets four cycles.
    sequence deselected; csN [*4]; endsequence
    sequence selected; !csN [*4]; endsequence
    a_pull_enable: assert property (
        deselected |-> dataOutReadyOe == ctrl.pullupEnable)
        else $error("enable differs from pullup bit");
    a_pull_high: assert property (
        deselected ##0 dataOutReadyOe |-> dataOutReady)
        else $error("idle pin not high");
    a_drive_sel: assert property (
        selected |-> dataOutReadyOe)
        else $error("pin not driven while selected");
    a_shot_pulse: assert property (
        singleShotStart |=> !singleShotStart)
        else $error("start pulse too long");
    a_shot_idle: assert property (
        singleShotStart |-> !convBusy)
        else $error("start during conversion");
    a_shot_mode: assert property (
        singleShotStart |-> !ctrl.continuous)
        else $error("start while continuous");
    a_gain_code: assert property (
        ctrl.fullScaleRange <= FSR_0256)
        else $error("bad range code");
    a_rate_code: assert property (
        ctrl.samplesPerSec inside {10'h008, 10'h010, 10'h020, 10'h040,
                                   10'h080, 10'h0fa, 10'h1db, 10'h35c})
        else $error("bad rate");
    a_cfg_after_fall: assert property (
        !$stable(ctrl) |-> !sclk)
        else $error("config changed with clock high");
endmodule // adc_cfg_monitor
bind adc_config_serial_port adc_cfg_monitor mon (.core_clk(core_clk),
    .rst_n(rst_n), .sclk(sclk), .csN(csN), .convBusy(convBusy),
    .dataOutReady(dataOutReady), .dataOutReadyOe(dataOutReadyOe),
    .ctrl(ctrl), .singleShotStart(singleShotStart));
`default_nettype wire

// file: tb/spi_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_model (
    // Serial lines toward the device
    output logic     sclk,
    output logic     csN,
    output logic     dataIn,
    // Resolved level of the shared return line
    input wire logic pinLevel
);
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        dataIn = 1'b0;
    end
    task automatic hold(input logic level);
        csN = level;
    endtask
    // The odd start delay keeps the link edges off the core clock grid.
    task automatic frame(input logic [31:0] tx, input int bits,
                         output logic [31:0] rx);
        rx = 32'h0;
        csN = 1'b0;
        #81.3;
        for (int i = bits - 1; i >= 0; i--) begin
            sclk = 1'b1;
            dataIn = tx[i];
            #80;
            sclk = 1'b0;
            rx[i] = pinLevel;
            #80;
        end
        csN = 1'b1;
        #320;
    endtask
endmodule // spi_master_model
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import adc_cfg_pkg::*;
;
    localparam logic [9:0]  RATES [8] = '{10'h008, 10'h010, 10'h020,
        10'h040, 10'h080, 10'h0fa, 10'h1db, 10'h35c};
    localparam logic [15:0] BAD [5] = '{16'h0e60, 16'h0e64, 16'h0e66,
        16'h0000, 16'hffff};
    logic        core_clk;
    logic        rst_n;
    logic        sclk;
    logic        csN;
    logic        dataIn;
    logic        dataOutReady;
    logic        dataOutReadyOe;
    logic        convValid;
    logic        convReady;
    logic [15:0] convData;
    logic        convBusy;
    adc_ctrl_t   ctrl;
    logic        singleShotStart;
    logic        pinHold = 1'b0;
    logic        pinLevel;
    int          fails = 0;
    int          num_checks = 0;
    int          shots = 0;
    adc_config_serial_port adc_config_serial_port_inst (.core_clk, .rst_n,
        .sclk, .csN, .dataIn, .dataOutReady, .dataOutReadyOe, .convValid,
        .convReady, .convData, .convBusy, .ctrl, .singleShotStart);
    spi_master_model spi (.sclk, .csN, .dataIn, .pinLevel);
    // A floating line shows the inverse of its last level, never a guess.
    assign pinLevel = dataOutReadyOe ? dataOutReady : ~pinHold;
    always @(posedge core_clk) begin
        if (dataOutReadyOe) pinHold <= dataOutReady;
        if (singleShotStart) shots <= shots + 1;
    end
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] expCtrl(input logic [15:0] w);
        adc_ctrl_t c;
        c.fullScaleRange = fsr_t'((w[11:9] > 3'h5) ? 3'h5 : w[11:9]);
        c.continuous = ~w[8];
        c.samplesPerSec = RATES[w[7:5]];
        c.tempSensor = w[4];
        c.pullupEnable = w[3];
        c.inputMux = w[14:12];
        return 32'(c);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s %h vs %h", $time, what, got, exp);
        end
    endtask
    task automatic pushConv(input logic [15:0] d, input int tries,
                            output logic taken);
        @(posedge core_clk);
        #1 convValid = 1'b1;
        convData = d;
        taken = 1'b0;
        for (int k = 0; k < tries && !taken; k++) begin
            @(posedge core_clk);
            taken = convReady;
        end
        #1 convValid = 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        $display("unexpected at %0t: run hung", $time);
        finish_test();
    end
    initial begin
        logic [31:0] rx;
        logic [31:0] saved;
        logic [15:0] w;
        logic        taken;
        int          n;
        rst_n = 1'b0;
        convValid = 1'b0;
        convData = 16'h0;
        convBusy = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        check(32'(ctrl), expCtrl(CFG_RESET), "reset");
        for (int i = 0; i < 8; i++) begin
            w = {1'b0, 3'(i), 3'(i), i[0], 3'(7 - i), i[1], i[2], 3'h2};
            spi.frame({w, w}, 32, rx);
            check(rx, {DATA_RESET, 1'b0, w[14:1], 1'b1}, "echo");
            check(32'(ctrl), expCtrl(w), "decode");
            check(32'(dataOutReadyOe), 32'(w[3]), "idle pin");
        end
        $display("test decode done");
        saved = 32'(ctrl);
        foreach (BAD[k]) begin
            spi.frame({BAD[k], BAD[k]}, 32, rx);
            check(32'(ctrl), saved, "refused");
        end
        w[15] = 1'b1;
        spi.frame({w, 16'h0}, 32, rx);
        check(32'(shots), 32'h1, "start");
        check(rx[15:0], {1'b0, w[14:1], 1'b1}, "start bit");
        @(posedge core_clk);
        #1 convBusy = 1'b1;
        spi.frame({w, 16'h0}, 32, rx);
        check(32'(shots), 32'h1, "busy start");
        @(posedge core_clk);
        #1 convBusy = 1'b0;
        $display("test start done");
        pushConv(16'ha5c3, 20, taken);
        repeat (8) @(posedge core_clk);
        for (int k = 0; k < 2; k++) begin
            spi.frame(32'h0, 16, rx);
            check(rx, 32'h0000a5c3, "result");
        end
        spi.hold(1'b0);
        n = 0;
        for (int k = 0; k < 10; k++) begin
            pushConv(16'(k), 1, taken);
            n += int'(taken);
        end
        check(32'(n), 32'(FIFO_DEPTH), "buffer full");
        spi.hold(1'b1);
        pushConv(16'h1234, 50, taken);
        check(32'(taken), 32'h1, "buffer drains");
        $display("test results done");
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
